// file: hdl/pfoc_filter_chain.sv
// filter chain top: axi4-lite registers, path select and sequencing
`timescale 1ns/10ps
module pfoc_filter_chain
   import pfoc_pkg::*;
(
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   // axi4-lite write address
   input  wire logic [31:0]        s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   // axi4-lite write response
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   // axi4-lite read address
   input  wire logic [31:0]        s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   // axi4-lite read data
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // recording samples from the adc side
   input  wire logic signed [15:0] rec_l,
   input  wire logic signed [15:0] rec_r,
   input  wire logic               rec_valid,
   // playback samples from the serial interface
   input  wire logic signed [15:0] play_l,
   input  wire logic signed [15:0] play_r,
   input  wire logic               play_valid,
   output logic                    in_ready,
   // filtered samples towards level control
   output logic signed [15:0]      out_l,
   output logic signed [15:0]      out_r,
   output logic                    out_rec_valid,
   output logic                    out_play_valid
);

   //==============================================================
   // state
   typedef struct packed {
      logic [CTRL_W-1:0]  ctrl;
      logic [13:0]        wind_a;
      logic [13:0]        wind_b;
      logic [13:0]        sep_a;
      logic [13:0]        sep_b;
      logic [15:0]        tone_a;
      logic [13:0]        tone_b;
      logic [15:0]        tone_c;
      logic               aw_got;
      logic [7:0]         awaddr;
      logic               w_got;
      logic [31:0]        wdata;
      logic [3:0]         wstrb;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               rvalid;
      logic [31:0]        rdata;
      logic [1:0]         rresp;
      pfoc_phase_t        phase;
      pfoc_path_t         run_path;
      logic               stereo;
      logic signed [15:0] x_l;
      logic signed [15:0] x_r;
      logic signed [15:0] o_l;
      logic signed [15:0] o_r;
      logic               o_rec;
      logic               o_play;
      logic [15:0]        count;
   } pfoc_state_t;

   pfoc_state_t        st;
   pfoc_state_t        next_st;

   // stage wiring, index 0 left, 1 right
   logic signed [15:0] wind_y [2];
   logic signed [15:0] sep_y  [2];
   logic signed [15:0] tone_y [2];
   logic signed [15:0] sep_x  [2];
   logic signed [15:0] tone_x [2];
   logic signed [15:0] wind_a16;
   logic signed [15:0] wind_c16;
   logic signed [15:0] sep_a16;
   logic signed [15:0] sep_c16;
   pfoc_path_t         path;
   logic               mono;
   logic               wind_en;
   logic               sep_en;
   logic               tone_en;
   logic               chain_clear;
   logic               take;
   logic               wr_fire;
   logic [31:0]        wr_word;
   logic signed [16:0] half_diff;

   //==============================================================
   // helpers
   // path from the power bits; loopback deliberately not looked at
   function automatic pfoc_path_t path_of(input logic [CTRL_W-1:0] c);
      if (c[B_LADC] || c[B_RADC]) begin
         return PATH_REC;
      end
      if (c[B_DAC]) begin
         return PATH_PLAY;
      end
      return PATH_OFF;
   endfunction : path_of

   function automatic logic mapped(input logic [7:0] ad);
      return ad == OFF_CTRL || ad == OFF_WIND || ad == OFF_SEP ||
             ad == OFF_TONE_AB || ad == OFF_TONE_C || ad == OFF_STATUS;
   endfunction : mapped

   // register image as software sees it
   function automatic logic [31:0] reg_word(input logic [7:0] ad,
                                            input pfoc_state_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (ad)
         OFF_CTRL:    w[CTRL_W-1:0] = s.ctrl;
         OFF_WIND:    w = {2'h0, s.wind_b, 2'h0, s.wind_a};
         OFF_SEP:     w = {2'h0, s.sep_b, 2'h0, s.sep_a};
         OFF_TONE_AB: w = {2'h0, s.tone_b, s.tone_a};
         OFF_TONE_C:  w[15:0] = s.tone_c;
         OFF_STATUS:  w = {s.count, 12'h000, s.phase != PH_IDLE, s.stereo,
                           path_of(s.ctrl)};
         default:     w = 32'h0000_0000;
      endcase
      return w;
   endfunction : reg_word

   // byte-lane merge of a write into the current image
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return m;
   endfunction : merge

   // compensation gain as a left shift
   function automatic int gain_shift(input logic [1:0] g);
      if (g[1]) begin
         return GAIN24_SHIFT;
      end
      return g[0] ? GAIN12_SHIFT : 0;
   endfunction : gain_shift

   //==============================================================
   // decoded controls
   assign path = path_of(st.ctrl);
   assign mono = st.ctrl[B_MIX];
   assign chain_clear = (path == PATH_OFF);
   assign wind_en = st.ctrl[B_WEN];
   // mono mix leaves only the wind stage usable
   assign sep_en = st.ctrl[B_SEN] && !mono;
   assign tone_en = st.ctrl[B_TEN] && !mono;
   // 14-bit coefficients widened; hpf zero at z=1, lpf zero at z=-1
   assign wind_a16 = 16'(signed'(st.wind_a));
   assign sep_a16 = 16'(signed'(st.sep_a));
   assign wind_c16 = st.ctrl[B_WTYP] ? wind_a16 : -wind_a16;
   assign sep_c16 = st.ctrl[B_STYP] ? sep_a16 : -sep_a16;
   assign half_diff = (17'(sep_y[0]) - 17'(sep_y[1])) >>> 1;

   //==============================================================
   // three stages per channel
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      // emphasis: half the filtered l-r difference, mirrored on r
      always_comb begin
         sep_x[ch] = wind_y[ch];
         if (st.stereo) begin
            tone_x[ch] = pfoc_sat(ch == 0 ? 34'(wind_y[ch]) + 34'(half_diff)
                                          : 34'(wind_y[ch]) - 34'(half_diff));
         end else begin
            tone_x[ch] = wind_y[ch];
         end
      end

      pfoc_iir_stage u_wind (
         .clk_sys  (clk_sys),
         .rst_n    (rst_n),
         .step     (st.phase == PH_WIND),
         .enable   (wind_en),
         .mute_off (1'b0),
         .clear    (chain_clear),
         .x        (ch == 0 ? st.x_l : st.x_r),
         .a        (wind_a16),
         .b        (st.wind_b),
         .c        (wind_c16),
         .y        (wind_y[ch])
      );

      // separation coefficients fix the emphasis depth
      pfoc_iir_stage u_sep (
         .clk_sys  (clk_sys),
         .rst_n    (rst_n),
         .step     (st.phase == PH_SEP),
         .enable   (sep_en),
         .mute_off (1'b1),
         .clear    (chain_clear),
         .x        (sep_x[ch]),
         .a        (sep_a16),
         .b        (st.sep_b),
         .c        (sep_c16),
         .y        (sep_y[ch])
      );

      pfoc_iir_stage u_tone (
         .clk_sys  (clk_sys),
         .rst_n    (rst_n),
         .step     (st.phase == PH_TONE),
         .enable   (tone_en),
         .mute_off (1'b0),
         .clear    (chain_clear),
         .x        (tone_x[ch]),
         .a        (st.tone_a),
         .b        (st.tone_b),
         .c        (st.tone_c),
         .y        (tone_y[ch])
      );
   end

   //==============================================================
   // handshakes
   assign s_axi_awready = !st.aw_got && !st.bvalid;
   assign s_axi_wready = !st.w_got && !st.bvalid;
   assign s_axi_arready = !st.rvalid;
   assign in_ready = (st.phase == PH_IDLE) && (path != PATH_OFF);
   assign take = in_ready && (path == PATH_REC ? rec_valid : play_valid);
   assign wr_fire = st.aw_got && st.w_got && !st.bvalid;
   assign wr_word = merge(reg_word(st.awaddr, st), st.wdata, st.wstrb);

   //==============================================================
   // next state: bus slave, then the sample sequencer
   always_comb begin
      next_st = st;
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_got = 1'b1;
         next_st.awaddr = {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      // write lands once both halves are held
      if (wr_fire) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = mapped(st.awaddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (st.awaddr)
            OFF_CTRL: begin
               next_st.ctrl = wr_word[CTRL_W-1:0];
            end
            OFF_WIND: begin
               next_st.wind_a = wr_word[13:0];
               next_st.wind_b = wr_word[B_COEF_B +: 14];
            end
            OFF_SEP: begin
               next_st.sep_a = wr_word[13:0];
               next_st.sep_b = wr_word[B_COEF_B +: 14];
            end
            OFF_TONE_AB: begin
               next_st.tone_a = wr_word[15:0];
               next_st.tone_b = wr_word[B_COEF_B +: 14];
            end
            OFF_TONE_C: begin
               next_st.tone_c = wr_word[15:0];
            end
            default: begin
               next_st.bvalid = 1'b1;                // status and holes: no store
            end
         endcase
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = reg_word({s_axi_araddr[7:2], 2'h0}, st);
         next_st.rresp = mapped({s_axi_araddr[7:2], 2'h0}) ? RESP_OKAY : RESP_SLVERR;
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end

      // sequencer: one pair per sample period, three stage steps then emit
      next_st.o_rec = 1'b0;
      next_st.o_play = 1'b0;
      unique case (st.phase)
         PH_IDLE: begin
            if (take) begin
               next_st.phase = PH_WIND;
               next_st.run_path = path;
               if (path == PATH_PLAY) begin
                  next_st.x_l = play_l;
                  next_st.x_r = play_r;
                  next_st.stereo = 1'b1;
               end else begin
                  next_st.stereo = st.ctrl[B_LADC] && st.ctrl[B_RADC] && !mono;
                  if (!st.ctrl[B_LADC]) begin
                     next_st.x_l = rec_r;
                     next_st.x_r = rec_r;
                  end else if (!st.ctrl[B_RADC]) begin
                     next_st.x_l = rec_l;
                     next_st.x_r = rec_l;
                  end else if (mono) begin
                     next_st.x_l = 16'((17'(rec_l) + 17'(rec_r)) >>> 1);
                     next_st.x_r = 16'((17'(rec_l) + 17'(rec_r)) >>> 1);
                  end else begin
                     next_st.x_l = rec_l;
                     next_st.x_r = rec_r;
                  end
               end
            end
         end
         PH_WIND: next_st.phase = PH_SEP;
         PH_SEP:  next_st.phase = PH_TONE;
         PH_TONE: next_st.phase = PH_EMIT;
         PH_EMIT: begin
            // gain after the tone stage, saturated
            next_st.o_l = pfoc_sat(34'(tone_y[0]) <<< gain_shift(st.ctrl[B_GAIN +: 2]));
            next_st.o_r = pfoc_sat(34'(tone_y[1]) <<< gain_shift(st.ctrl[B_GAIN +: 2]));
            next_st.o_rec = (st.run_path == PATH_REC);
            next_st.o_play = (st.run_path == PATH_PLAY);
            next_st.count = st.count + 16'h0001;
            next_st.phase = PH_IDLE;
         end
      endcase
      // power-down aborts a sample in flight
      if (chain_clear) begin
         next_st.phase = PH_IDLE;
         next_st.o_rec = 1'b0;
         next_st.o_play = 1'b0;
      end
   end

   // the single state register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   //==============================================================
   // outputs
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign out_l = st.o_l;
   assign out_r = st.o_r;
   assign out_rec_valid = st.o_rec;
   assign out_play_valid = st.o_play;

   //==============================================================
   // checks
   a_off_silent: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (path == PATH_OFF) |=> !out_rec_valid && !out_play_valid)
      else $error("output while chain powered down");
   a_play_only_dac: assert property (@(posedge clk_sys) disable iff (!rst_n)
      take && st.ctrl[B_DAC] && !st.ctrl[B_LADC] && !st.ctrl[B_RADC]
      |-> ##5 out_play_valid && !out_rec_valid)
      else $error("dac-only sample not on playback path");
   a_rec_any_adc: assert property (@(posedge clk_sys) disable iff (!rst_n)
      take && (st.ctrl[B_LADC] || st.ctrl[B_RADC]) && !$past(chain_clear)
      |-> ##5 (out_rec_valid || $past(chain_clear, 1)))
      else $error("adc sample not on recording path");
   a_coef_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !wr_fire |=> $stable(st.wind_a) && $stable(st.tone_c) && $stable(st.sep_b))
      else $error("coefficient changed without a write");
   a_sep_mute: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.phase == PH_SEP) && !sep_en && !chain_clear |=> sep_y[0] == 16'sh0000)
      else $error("disabled separation stage not silent");
   a_wind_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.phase == PH_WIND) && !wind_en && !chain_clear |=> wind_y[1] == $past(st.x_r))
      else $error("disabled wind stage not transparent");
   a_mix_average: assert property (@(posedge clk_sys) disable iff (!rst_n)
      take && path == PATH_REC && mono && st.ctrl[B_LADC] && st.ctrl[B_RADC]
      |=> st.x_l == st.x_r && !st.stereo)
      else $error("mono mix did not feed both channels alike");
   a_mono_tone_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mono |-> !tone_en && !sep_en)
      else $error("tone or separation stage active under mono mix");
   a_one_per_take: assert property (@(posedge clk_sys) disable iff (!rst_n)
      take |=> !in_ready [*4])
      else $error("second sample accepted inside one period");

endmodule : pfoc_filter_chain

// file: hdl/pfoc_pkg.sv
// constants, types and helpers for the first-order filter chain
//==============================================================
package pfoc_pkg;

   //==============================================================
   // register byte offsets
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_WIND    = 8'h04;
   localparam logic [7:0] OFF_SEP     = 8'h08;
   localparam logic [7:0] OFF_TONE_AB = 8'h0C;
   localparam logic [7:0] OFF_TONE_C  = 8'h10;
   localparam logic [7:0] OFF_STATUS  = 8'h14;

   //==============================================================
   // control register bit positions, plus the b-coefficient field offset
   localparam int B_LADC  = 0;
   localparam int B_RADC  = 1;
   localparam int B_DAC   = 2;
   localparam int B_LOOP  = 3;
   localparam int B_MIX   = 4;
   localparam int B_WEN   = 5;
   localparam int B_SEN   = 6;
   localparam int B_TEN   = 7;
   localparam int B_WTYP  = 8;
   localparam int B_STYP  = 9;
   localparam int B_GAIN  = 10;
   localparam int CTRL_W  = 12;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
   localparam int B_COEF_B = 16;

   //==============================================================
   // arithmetic and bus constants
   localparam int COEF_FRAC = 13;
   localparam int GAIN12_SHIFT = 2;
   localparam int GAIN24_SHIFT = 4;
   localparam logic signed [33:0] SMAX = 34'sh0_0000_7FFF;
   localparam logic signed [33:0] SMIN = -34'sh0_0000_8000;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {PATH_OFF, PATH_PLAY, PATH_REC} pfoc_path_t;
   typedef enum logic [2:0] {PH_IDLE, PH_WIND, PH_SEP, PH_TONE, PH_EMIT} pfoc_phase_t;

   // clamp a wide signed value to the 16-bit sample range
   function automatic logic signed [15:0] pfoc_sat(input logic signed [33:0] v);
      if (v > SMAX) begin
         return 16'sh7FFF;
      end
      if (v < SMIN) begin
         return -16'sh8000;
      end
      return v[15:0];
   endfunction : pfoc_sat

endpackage : pfoc_pkg

// file: hdl/pfoc_iir_stage.sv
// one first-order iir section with history, bypass and mute
`timescale 1ns/10ps
module pfoc_iir_stage
   import pfoc_pkg::*;
(
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   // control
   input  wire logic               step,
   input  wire logic               enable,
   input  wire logic               mute_off,
   input  wire logic               clear,
   // sample and coefficients
   input  wire logic signed [15:0] x,
   input  wire logic signed [15:0] a,
   input  wire logic signed [13:0] b,
   input  wire logic signed [15:0] c,
   output logic signed [15:0]      y
);

   typedef struct packed {
      logic signed [15:0] x1;
      logic signed [15:0] y1;
      logic signed [15:0] y;
   } pfoc_stage_t;

   pfoc_stage_t        st;
   pfoc_stage_t        next_st;
   logic signed [33:0] acc;
   logic signed [15:0] ynew;

   //==============================================================
   // y = (a*x + c*x1 - b*y1) / 2^13
   always_comb begin
      next_st = st;
      acc = a * x + c * st.x1 - b * st.y1;
      ynew = pfoc_sat(acc >>> COEF_FRAC);
      if (clear) begin
         next_st = '0;
      end else if (!enable) begin
         // history dropped at once, not only on a step, so a re-enable starts clean
         next_st.x1 = 16'sh0000;
         next_st.y1 = 16'sh0000;
         if (step) begin
            next_st.y = mute_off ? 16'sh0000 : x;
         end
      end else if (step) begin
         next_st.y = ynew;
         next_st.x1 = x;
         next_st.y1 = ynew;
      end
   end

   // single state register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign y = st.y;

endmodule : pfoc_iir_stage

// file: verification/pfoc_src_model.sv
// sample source model standing in for the adc decimator and serial input
`timescale 1ns/10ps
module pfoc_src_model (
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   // bench request
   input  wire logic               go,
   input  wire logic               to_rec,
   input  wire logic signed [15:0] l,
   input  wire logic signed [15:0] r,
   output logic                    sent,
   // towards the chain
   input  wire logic               in_ready,
   output logic signed [15:0]      sl,
   output logic signed [15:0]      sr,
   output logic                    rec_v,
   output logic                    play_v
);
   //==============================================================
   // one strobe per request; data inverted off the strobe so no stale value reads
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         {rec_v, play_v, sent, sl, sr} <= '0;
      end else if (rec_v || play_v) begin
         {rec_v, play_v, sent} <= 3'b001;
         sl <= ~sl;
         sr <= ~sr;
      end else if (go && !sent && in_ready) begin
         {sl, sr, rec_v, play_v} <= {l, r, to_rec, !to_rec};
      end else if (!go) begin
         sent <= 1'b0;
      end
   end
endmodule : pfoc_src_model

// file: verification/tb_top.sv
// self-checking bench for the filter chain
`timescale 1ns/10ps
module tb_top;
   import pfoc_pkg::*;
   logic               clk_sys, rst_n, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
   logic               go, to_rec, sent, rdy, rec_v, play_v, orv, opv;
   logic        [31:0] awa, wd, ara, rdat, d;
   logic        [1:0]  bresp, rresp, rs;
   logic signed [15:0] sl, sr, gl, gr, o_l, o_r;
   int                 miscompares, samples_checked;
   //==============================================================
   // clock and instances
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   pfoc_filter_chain pfoc_filter_chain_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .rec_l(sl), .rec_r(sr), .rec_valid(rec_v), .play_l(sl),
      .play_r(sr), .play_valid(play_v), .in_ready(rdy), .out_l(o_l), .out_r(o_r),
      .out_rec_valid(orv), .out_play_valid(opv));
   pfoc_src_model pfoc_src_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .go(go),
      .to_rec(to_rec), .l(gl), .r(gr), .sent(sent), .in_ready(rdy), .sl(sl), .sr(sr),
      .rec_v(rec_v), .play_v(play_v));
   //==============================================================
   // shared tasks
   task automatic end_of_test;
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // a wait that used its bound ends the run at once
   task automatic tmo(input int n);
      if (n >= 40) begin
         miscompares++;
         end_of_test();
      end
   endtask : tmo
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
      int n;
      @(posedge clk_sys);
      n = 0;
      awa <= {24'h0, a};
      wd  <= v;
      awv <= 1'b1;
      wv  <= 1'b1;
      br  <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (awr === 1'b1) awv <= 1'b0;
         if (wrd === 1'b1) wv <= 1'b0;
      end while (bv !== 1'b1 && n < 40);
      rsp = bresp;
      br <= 1'b0;
      tmo(n);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
      int n;
      @(posedge clk_sys);
      n = 0;
      ara <= {24'h0, a};
      arv <= 1'b1;
      rr  <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (arr === 1'b1) arv <= 1'b0;
      end while (rv !== 1'b1 && n < 40);
      v = rdat;
      rsp = rresp;
      rr <= 1'b0;
      tmo(n);
   endtask : rd
   // one stereo sample through the chain, then compare both channels
   task automatic smp(input logic rec, input logic [15:0] l, r, el, er);
      int n;
      @(posedge clk_sys);
      n = 0;
      to_rec <= rec;
      gl <= l;
      gr <= r;
      go <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (sent === 1'b1) go <= 1'b0;
      end while ((rec ? orv : opv) !== 1'b1 && n < 40);
      tmo(n);
      chk({16'h0, o_l}, {16'h0, el});
      chk({16'h0, o_r}, {16'h0, er});
   endtask : smp
   //==============================================================
   // scenarios
   task automatic t_regs;
      logic [31:0] c[4] = '{32'h004, 32'h00B, 32'h00E, 32'h008};
      logic [31:0] p[4] = '{32'h1, 32'h2, 32'h2, 32'h0};
      rd(OFF_CTRL, d, rs);
      chk(d, 32'h0);
      chk({31'h0, rdy}, 32'h0);
      wr(8'h20, 32'h1, rs);
      chk({30'h0, rs}, 32'h2);
      rd(8'h20, d, rs);
      chk(d, 32'h0);
      chk({30'h0, rs}, 32'h2);
      wr(OFF_WIND, 32'h1ABC_1234, rs);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_CTRL, c[i], rs);
         rd(OFF_STATUS, d, rs);
         chk(d & 32'h3, p[i]);
      end
      rd(OFF_WIND, d, rs);
      chk(d, 32'h1ABC_1234);
   endtask : t_regs
   // each gain code on a bypassed stereo sample; the top codes saturate
   task automatic t_gain;
      logic [15:0] el[4] = '{16'h1000, 16'h4000, 16'h7FFF, 16'h7FFF};
      logic [15:0] er[4] = '{16'hF000, 16'hC000, 16'h8000, 16'h8000};
      for (int g = 0; g < 4; g++) begin
         wr(OFF_CTRL, 32'h003 | (g << 10), rs);
         smp(1'b1, 16'h1000, 16'hF000, el[g], er[g]);
      end
   endtask : t_gain
   task automatic t_paths;
      wr(OFF_CTRL, 32'h013, rs);
      smp(1'b1, 16'h0100, 16'h0300, 16'h0200, 16'h0200);
      wr(OFF_CTRL, 32'h001, rs);
      smp(1'b1, 16'h0111, 16'h0222, 16'h0111, 16'h0111);
      wr(OFF_CTRL, 32'h004, rs);
      smp(1'b0, 16'h1357, 16'h2468, 16'h1357, 16'h2468);
   endtask : t_paths
   // half-scale a with no feedback: low-pass sums, high-pass differences
   task automatic t_wind;
      wr(OFF_CTRL, 32'h003, rs);
      wr(OFF_WIND, 32'h0000_1000, rs);
      wr(OFF_CTRL, 32'h123, rs);
      smp(1'b1, 16'h0400, 16'h0400, 16'h0200, 16'h0200);
      smp(1'b1, 16'h0400, 16'h0400, 16'h0400, 16'h0400);
      wr(OFF_CTRL, 32'h003, rs);
      wr(OFF_CTRL, 32'h023, rs);
      smp(1'b1, 16'h0400, 16'h0400, 16'h0200, 16'h0200);
      smp(1'b1, 16'h0400, 16'h0400, 16'h0000, 16'h0000);
   endtask : t_wind
   // emphasis from a half-scale low-pass separation stage, unity tone stage, then mono mix
   task automatic t_emph;
      wr(OFF_CTRL, 32'h003, rs);
      wr(OFF_SEP, 32'h0000_1000, rs);
      wr(OFF_TONE_AB, 32'h0000_2000, rs);
      wr(OFF_CTRL, 32'h2C3, rs);
      smp(1'b1, 16'h0400, 16'h0000, 16'h0500, 16'hFF00);
      smp(1'b1, 16'h0400, 16'h0000, 16'h0600, 16'hFE00);
      wr(OFF_CTRL, 32'h2D3, rs);
      smp(1'b1, 16'h0100, 16'h0300, 16'h0200, 16'h0200);
      rd(OFF_STATUS, d, rs);
      chk(d, 32'h000E_0002);
   endtask : t_emph
   //==============================================================
   // main sequence
   initial begin
      {miscompares, samples_checked} = '0;
      {rst_n, awv, wv, br, arv, rr, go, to_rec, awa, wd, ara, gl, gr} = '0;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_regs();
      t_gain();
      t_paths();
      t_wind();
      t_emph();
      end_of_test();
   end
endmodule : tb_top
